// ### cwd_cfg.svh
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH

// Window counts
`define CWD_NUM_MEM 5
`define CWD_NUM_IO 2

// Register offsets
`define CWD_MCTL_A 8'h16
`define CWD_MCTL_C 8'h25
`define CWD_MEM_BASE 8'h40
`define CWD_MEM_SPAN 8'h28
`define CWD_STAT_A 8'h68
`define CWD_STAT_B 8'h69
`define CWD_IO_BASE 8'h70
`define CWD_IO_SPAN 8'h10

// Byte positions inside one window block
`define CWD_WB_START_LO 3'h0
`define CWD_WB_START_HI 3'h1
`define CWD_WB_END_LO 3'h2
`define CWD_WB_END_HI 3'h3
`define CWD_WB_OFF_LO 3'h4
`define CWD_WB_OFF_HI 3'h5
`define CWD_WB_UPPER 3'h6
`define CWD_WB_MCTL 3'h7
`define CWD_WB_ICTL 3'h6

// Control field positions
`define CWD_CTL_EN 0
`define CWD_CTL_TSET 1
`define CWD_CTL_REG 2
`define CWD_CTL_WP 3
`define CWD_CTL_FIXED 2
`define CWD_CTL_W16 3
`define CWD_CTL_AUTO 4
`define CWD_ZV_EN_BIT 0
`define CWD_ZV_ARM_BIT 7

// Reset values and address output-enable masks (all driven, bypass)
`define CWD_REG_RST 8'h00
`define CWD_OE_ALL 26'h3ffffff
`define CWD_OE_ZV 26'h000000f

`endif

// ### cwd_pkg.sv
package cwd_pkg;
    typedef logic [7:0] cwd_byte_t;
    typedef logic [7:0][7:0] cwd_win_t;
    typedef logic [25:0] cwd_caddr_t;
endpackage

// ### cwd_mem_match.sv
`include "cwd_cfg.svh"

// One memory window: page compare, range compare and translation
module cwd_mem_match
    import cwd_pkg::*;
(
    input wire cwd_win_t win,
    input wire logic [31:0] host_addr,
    output logic hit,
    output cwd_caddr_t card_addr
);
    logic [11:0] start_pg;
    logic [11:0] end_pg;
    logic [13:0] offset;
    logic [11:0] page;

    assign start_pg = {win[`CWD_WB_START_HI][3:0], win[`CWD_WB_START_LO]};
    assign end_pg = {win[`CWD_WB_END_HI][3:0], win[`CWD_WB_END_LO]};
    assign offset = {win[`CWD_WB_OFF_HI][5:0], win[`CWD_WB_OFF_LO]};
    assign page = host_addr[23:12];

    assign hit = win[`CWD_WB_MCTL][`CWD_CTL_EN]
        && (host_addr[31:24] == win[`CWD_WB_UPPER])
        && (page >= start_pg) && (page <= end_pg);

    // Carry out of bit 25 is dropped
    assign card_addr = {2'b00, host_addr[23:0]} + {offset, 12'h000};
endmodule

// ### cwd_io_match.sv
`include "cwd_cfg.svh"

// One I/O window: byte-resolution range compare and translation
module cwd_io_match
    import cwd_pkg::*;
(
    input wire cwd_win_t win,
    input wire logic [31:0] host_addr,
    output logic hit,
    output cwd_caddr_t card_addr
);
    logic [15:0] start_a;
    logic [15:0] end_a;
    logic [15:0] offset;
    logic [15:0] io_sum;

    assign start_a = {win[`CWD_WB_START_HI], win[`CWD_WB_START_LO]};
    assign end_a = {win[`CWD_WB_END_HI], win[`CWD_WB_END_LO]};
    assign offset = {win[`CWD_WB_OFF_HI], win[`CWD_WB_OFF_LO]};

    assign hit = win[`CWD_WB_ICTL][`CWD_CTL_EN]
        && (host_addr[31:16] == 16'h0000)
        && (host_addr[15:0] >= start_a) && (host_addr[15:0] <= end_a);

    assign io_sum = host_addr[15:0] + offset;
    assign card_addr = {10'h000, io_sum};
endmodule

// ### cwd_card_window_decoder.sv
// Summary of operation
// - Five memory and two I/O windows.
// - Disabled memory windows never claim accesses.
// - Memory bounds 4K granular within page.
// - Claim memory only between start and end.
// - Card address is host plus offset.
// - Upper field selects 16M host page.
// - Each window picks timing set 0/1.
// - Per-window attribute select drives REG active.
// - Protected windows drop writes, reads proceed.
// - Only enabled I/O windows claim accesses.
// - I/O bounds byte resolution, 64K space.
// - Auto sizing follows IOIS16 from card.
// - Fixed 8/16 width overrides auto sizing.
// - Bypass needs enable and arm both set.
// - Bypass floats card address A25..A4.
//
// Strobed register access was decided locally.
`include "cwd_cfg.svh"

module cwd_card_window_decoder
    import cwd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic host_req,
    input wire logic host_io,
    input wire logic host_write,
    input wire logic [31:0] host_addr,
    input wire logic card_iois16_n,
    output logic host_claim,
    output logic host_wp_drop,
    output logic card_req,
    output logic card_io,
    output logic card_write,
    output logic card_reg_n,
    output logic card_tset,
    output logic card_width16,
    output logic [25:0] card_addr_o,
    output logic [25:0] card_addr_oe,
    output logic zv_active
);

////////////////////////////////////////////////////////////////////////////
// Register file

    cwd_win_t mem_win_ff [`CWD_NUM_MEM];
    cwd_win_t nxt_mem_win [`CWD_NUM_MEM];
    cwd_win_t io_win_ff [`CWD_NUM_IO];
    cwd_win_t nxt_io_win [`CWD_NUM_IO];
    cwd_byte_t mctl_a_ff;
    cwd_byte_t nxt_mctl_a;
    cwd_byte_t mctl_c_ff;
    cwd_byte_t nxt_mctl_c;
    cwd_byte_t reg_rdata_ff;
    cwd_byte_t nxt_reg_rdata;
    logic [4:0] last_mem_hit_ff;
    logic [4:0] nxt_last_mem_hit;
    logic [1:0] last_io_hit_ff;
    logic [1:0] nxt_last_io_hit;
    logic iois16_n_meta_ff;
    logic iois16_n_sync_ff;

    logic [7:0] mem_rel;
    logic [7:0] io_rel;
    logic mem_sel;
    logic io_sel;
    logic [2:0] mem_idx;
    logic io_idx;
    logic [2:0] byt;

    assign mem_rel = reg_addr - `CWD_MEM_BASE;
    assign io_rel = reg_addr - `CWD_IO_BASE;
    assign mem_sel = (reg_addr >= `CWD_MEM_BASE) && (mem_rel < `CWD_MEM_SPAN);
    assign io_sel = (reg_addr >= `CWD_IO_BASE) && (io_rel < `CWD_IO_SPAN);
    assign mem_idx = mem_rel[5:3];
    assign io_idx = io_rel[3];
    assign byt = reg_addr[2:0];

    always_comb begin
        nxt_mem_win = mem_win_ff;
        nxt_io_win = io_win_ff;
        nxt_mctl_a = mctl_a_ff;
        nxt_mctl_c = mctl_c_ff;
        nxt_reg_rdata = `CWD_REG_RST;
        for (int i = 0; i < `CWD_NUM_MEM; i++) begin
            if (reg_wr && mem_sel && (mem_idx == 3'(i))) begin
                nxt_mem_win[i][byt] = reg_wdata;
            end
        end
        for (int i = 0; i < `CWD_NUM_IO; i++) begin
            if (reg_wr && io_sel && (io_idx == 1'(i))) begin
                nxt_io_win[i][byt] = reg_wdata;
            end
        end
        if (reg_wr && (reg_addr == `CWD_MCTL_A)) begin
            nxt_mctl_a = reg_wdata;
        end
        if (reg_wr && (reg_addr == `CWD_MCTL_C)) begin
            nxt_mctl_c = reg_wdata;
        end
        if (reg_rd) begin
            if (mem_sel) begin
                nxt_reg_rdata = mem_win_ff[mem_idx][byt];
            end else if (io_sel) begin
                nxt_reg_rdata = io_win_ff[io_idx][byt];
            end else if (reg_addr == `CWD_MCTL_A) begin
                nxt_reg_rdata = mctl_a_ff;
            end else if (reg_addr == `CWD_MCTL_C) begin
                nxt_reg_rdata = mctl_c_ff;
            end else if (reg_addr == `CWD_STAT_A) begin
                nxt_reg_rdata = {3'h0, last_mem_hit_ff};
            end else if (reg_addr == `CWD_STAT_B) begin
                nxt_reg_rdata = {zv_active, ~iois16_n_sync_ff, 4'h0,
                    last_io_hit_ff};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < `CWD_NUM_MEM; i++) begin
                mem_win_ff[i] <= '0;
            end
            for (int i = 0; i < `CWD_NUM_IO; i++) begin
                io_win_ff[i] <= '0;
            end
            mctl_a_ff <= `CWD_REG_RST;
            mctl_c_ff <= `CWD_REG_RST;
            reg_rdata_ff <= `CWD_REG_RST;
        end else begin
            mem_win_ff <= nxt_mem_win;
            io_win_ff <= nxt_io_win;
            mctl_a_ff <= nxt_mctl_a;
            mctl_c_ff <= nxt_mctl_c;
            reg_rdata_ff <= nxt_reg_rdata;
        end
    end

    assign reg_rdata = reg_rdata_ff;

////////////////////////////////////////////////////////////////////////////
// Card pin synchroniser

    always_ff @(posedge clk) begin
        if (reset) begin
            iois16_n_meta_ff <= 1'b1;
            iois16_n_sync_ff <= 1'b1;
        end else begin
            iois16_n_meta_ff <= card_iois16_n;
            iois16_n_sync_ff <= iois16_n_meta_ff;
        end
    end

////////////////////////////////////////////////////////////////////////////
// Window matchers

    logic [`CWD_NUM_MEM-1:0] mem_hit;
    cwd_caddr_t mem_caddr [`CWD_NUM_MEM];
    logic [`CWD_NUM_IO-1:0] io_hit;
    cwd_caddr_t io_caddr [`CWD_NUM_IO];

    for (genvar g = 0; g < `CWD_NUM_MEM; g++) begin : g_mem
        cwd_mem_match u_mem (
            .win(mem_win_ff[g]),
            .host_addr(host_addr),
            .hit(mem_hit[g]),
            .card_addr(mem_caddr[g])
        );
    end

    for (genvar g = 0; g < `CWD_NUM_IO; g++) begin : g_io
        cwd_io_match u_io (
            .win(io_win_ff[g]),
            .host_addr(host_addr),
            .hit(io_hit[g]),
            .card_addr(io_caddr[g])
        );
    end

////////////////////////////////////////////////////////////////////////////
// Claim and card-side request

    logic host_claim_ff, nxt_host_claim;
    logic host_wp_drop_ff, nxt_host_wp_drop;
    logic card_req_ff, nxt_card_req;
    logic card_io_ff, nxt_card_io;
    logic card_write_ff, nxt_card_write;
    logic card_reg_n_ff, nxt_card_reg_n;
    logic card_tset_ff, nxt_card_tset;
    logic card_width16_ff, nxt_card_width16;
    cwd_caddr_t card_addr_ff, nxt_card_addr;
    logic [25:0] card_addr_oe_ff, nxt_card_addr_oe;
    logic zv_active_ff, nxt_zv_active;
    cwd_byte_t sel_mctl;
    cwd_byte_t sel_ictl;
    cwd_caddr_t sel_mcaddr;
    cwd_caddr_t sel_icaddr;
    logic mem_any;
    logic io_any;
    logic io_w16;

    // Lowest-numbered window wins; overlap is left to software
    always_comb begin
        sel_mctl = `CWD_REG_RST;
        sel_ictl = `CWD_REG_RST;
        sel_mcaddr = '0;
        sel_icaddr = '0;
        for (int i = `CWD_NUM_MEM - 1; i >= 0; i--) begin
            if (mem_hit[i]) begin
                sel_mctl = mem_win_ff[i][`CWD_WB_MCTL];
                sel_mcaddr = mem_caddr[i];
            end
        end
        for (int i = `CWD_NUM_IO - 1; i >= 0; i--) begin
            if (io_hit[i]) begin
                sel_ictl = io_win_ff[i][`CWD_WB_ICTL];
                sel_icaddr = io_caddr[i];
            end
        end
    end

    assign mem_any = |mem_hit;
    assign io_any = |io_hit;
    assign io_w16 = sel_ictl[`CWD_CTL_FIXED] ? sel_ictl[`CWD_CTL_W16]
        : (sel_ictl[`CWD_CTL_AUTO] & ~iois16_n_sync_ff);

    always_comb begin
        nxt_host_claim = 1'b0;
        nxt_host_wp_drop = 1'b0;
        nxt_card_req = 1'b0;
        nxt_card_io = card_io_ff;
        nxt_card_write = card_write_ff;
        nxt_card_reg_n = card_reg_n_ff;
        nxt_card_tset = card_tset_ff;
        nxt_card_width16 = card_width16_ff;
        nxt_card_addr = card_addr_ff;
        nxt_last_mem_hit = last_mem_hit_ff;
        nxt_last_io_hit = last_io_hit_ff;
        if (host_req && !host_io && mem_any) begin
            nxt_host_claim = 1'b1;
            nxt_last_mem_hit = mem_hit;
            if (host_write && sel_mctl[`CWD_CTL_WP]) begin
                nxt_host_wp_drop = 1'b1;
            end else begin
                nxt_card_req = 1'b1;
                nxt_card_io = 1'b0;
                nxt_card_write = host_write;
                nxt_card_reg_n = ~sel_mctl[`CWD_CTL_REG];
                nxt_card_tset = sel_mctl[`CWD_CTL_TSET];
                nxt_card_width16 = 1'b1;
                nxt_card_addr = sel_mcaddr;
            end
        end else if (host_req && host_io && io_any) begin
            nxt_host_claim = 1'b1;
            nxt_last_io_hit = io_hit;
            nxt_card_req = 1'b1;
            nxt_card_io = 1'b1;
            nxt_card_write = host_write;
            nxt_card_reg_n = 1'b1;
            nxt_card_tset = sel_ictl[`CWD_CTL_TSET];
            nxt_card_width16 = io_w16;
            nxt_card_addr = sel_icaddr;
        end
        nxt_zv_active = mctl_a_ff[`CWD_ZV_EN_BIT]
            & mctl_c_ff[`CWD_ZV_ARM_BIT];
        nxt_card_addr_oe = nxt_zv_active ? `CWD_OE_ZV : `CWD_OE_ALL;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            host_claim_ff <= 1'b0;
            host_wp_drop_ff <= 1'b0;
            card_req_ff <= 1'b0;
            card_io_ff <= 1'b0;
            card_write_ff <= 1'b0;
            card_reg_n_ff <= 1'b1;
            card_tset_ff <= 1'b0;
            card_width16_ff <= 1'b0;
            card_addr_ff <= '0;
            card_addr_oe_ff <= `CWD_OE_ALL;
            zv_active_ff <= 1'b0;
            last_mem_hit_ff <= '0;
            last_io_hit_ff <= '0;
        end else begin
            host_claim_ff <= nxt_host_claim;
            host_wp_drop_ff <= nxt_host_wp_drop;
            card_req_ff <= nxt_card_req;
            card_io_ff <= nxt_card_io;
            card_write_ff <= nxt_card_write;
            card_reg_n_ff <= nxt_card_reg_n;
            card_tset_ff <= nxt_card_tset;
            card_width16_ff <= nxt_card_width16;
            card_addr_ff <= nxt_card_addr;
            card_addr_oe_ff <= nxt_card_addr_oe;
            zv_active_ff <= nxt_zv_active;
            last_mem_hit_ff <= nxt_last_mem_hit;
            last_io_hit_ff <= nxt_last_io_hit;
        end
    end

    assign host_claim = host_claim_ff;
    assign host_wp_drop = host_wp_drop_ff;
    assign card_req = card_req_ff;
    assign card_io = card_io_ff;
    assign card_write = card_write_ff;
    assign card_reg_n = card_reg_n_ff;
    assign card_tset = card_tset_ff;
    assign card_width16 = card_width16_ff;
    assign card_addr_o = card_addr_ff;
    assign card_addr_oe = card_addr_oe_ff;
    assign zv_active = zv_active_ff;

////////////////////////////////////////////////////////////////////////////
// Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic mem_en_any;
    logic io_en_any;
    cwd_win_t w0;
    cwd_caddr_t w0_expect;
    logic w0_in;

    always_comb begin
        mem_en_any = 1'b0;
        io_en_any = 1'b0;
        for (int i = 0; i < `CWD_NUM_MEM; i++) begin
            mem_en_any |= mem_win_ff[i][`CWD_WB_MCTL][`CWD_CTL_EN];
        end
        for (int i = 0; i < `CWD_NUM_IO; i++) begin
            io_en_any |= io_win_ff[i][`CWD_WB_ICTL][`CWD_CTL_EN];
        end
    end

    assign w0 = mem_win_ff[0];
    assign w0_expect = {2'b00, host_addr[23:0]}
        + {w0[`CWD_WB_OFF_HI][5:0], w0[`CWD_WB_OFF_LO], 12'h000};
    assign w0_in = w0[`CWD_WB_MCTL][`CWD_CTL_EN]
        && (host_addr[31:24] == w0[`CWD_WB_UPPER])
        && (host_addr[23:12] >= {w0[`CWD_WB_START_HI][3:0],
            w0[`CWD_WB_START_LO]})
        && (host_addr[23:12] <= {w0[`CWD_WB_END_HI][3:0],
            w0[`CWD_WB_END_LO]});

    sequence s_mem_req;
        host_req && !host_io;
    endsequence

    sequence s_w0_read;
        s_mem_req ##0 w0_in && !host_write;
    endsequence

    sequence s_zv_armed;
        mctl_a_ff[`CWD_ZV_EN_BIT] && mctl_c_ff[`CWD_ZV_ARM_BIT];
    endsequence

    property p_mem_disabled;
        s_mem_req ##0 !mem_en_any |=> !host_claim && !card_req;
    endproperty
    a_mem_disabled: assert property (p_mem_disabled)
        else $error("claim with all memory windows disabled");

    property p_w0_claim;
        s_w0_read ##1 !host_req |-> host_claim && card_req ##1 !card_req;
    endproperty
    a_w0_claim: assert property (p_w0_claim)
        else $error("window 0 hit not claimed as one pulse");

    property p_w0_addr;
        s_w0_read |=> card_addr_o == $past(w0_expect);
    endproperty
    a_w0_addr: assert property (p_w0_addr)
        else $error("memory translation wrong");

    property p_w0_attr;
        s_w0_read |=> card_reg_n != $past(w0[`CWD_WB_MCTL][`CWD_CTL_REG])
            && card_tset == $past(w0[`CWD_WB_MCTL][`CWD_CTL_TSET]);
    endproperty
    a_w0_attr: assert property (p_w0_attr)
        else $error("attribute select or timing set wrong");

    property p_wp_drop;
        s_mem_req ##0 mem_any && host_write && sel_mctl[`CWD_CTL_WP]
            |=> host_wp_drop && host_claim && !card_req;
    endproperty
    a_wp_drop: assert property (p_wp_drop)
        else $error("protected write reached the card");

    property p_io_disabled;
        host_req && host_io && !io_en_any |=> !host_claim && !card_req;
    endproperty
    a_io_disabled: assert property (p_io_disabled)
        else $error("claim with all I/O windows disabled");

    property p_io_size;
        host_req && host_io && io_hit[0] && !sel_ictl[`CWD_CTL_FIXED]
            |=> card_width16 == $past(sel_ictl[`CWD_CTL_AUTO]
            & ~iois16_n_sync_ff);
    endproperty
    a_io_size: assert property (p_io_size)
        else $error("automatic I/O sizing wrong");

    property p_io_fixed;
        host_req && host_io && io_any && sel_ictl[`CWD_CTL_FIXED]
            |=> card_io && card_width16 == $past(sel_ictl[`CWD_CTL_W16]);
    endproperty
    a_io_fixed: assert property (p_io_fixed)
        else $error("fixed I/O width not honoured");

    property p_zv;
        s_zv_armed |=> zv_active && card_addr_oe == `CWD_OE_ZV;
    endproperty
    a_zv: assert property (p_zv)
        else $error("bypass did not float upper address");

    property p_zv_off;
        !(mctl_a_ff[`CWD_ZV_EN_BIT] && mctl_c_ff[`CWD_ZV_ARM_BIT])
            |=> !zv_active && card_addr_oe == `CWD_OE_ALL;
    endproperty
    a_zv_off: assert property (p_zv_off)
        else $error("bypass entered without enable and arm");

endmodule

// ### cwd_card_model.sv
module cwd_card_model (
    input wire logic clk,
    input wire logic wide,
    output logic card_iois16_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Card drives IOIS16 low whenever the bench sets wide, with no address decode; the pin moves after an edge
    initial card_iois16_n = 1'b1;
    always @(posedge clk) begin
        card_iois16_n <= ~wide;
    end
endmodule

// ### cwd_card_window_decoder_bench.sv
`include "cwd_cfg.svh"

module cwd_card_window_decoder_bench;
    import cwd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic host_req = 1'b0;
    logic host_io = 1'b0;
    logic host_write = 1'b0;
    logic [31:0] host_addr = 32'h0;
    logic card_iois16_n;
    logic host_claim, host_wp_drop, card_req, card_io, card_write;
    logic card_reg_n, card_tset, card_width16, zv_active;
    logic [25:0] card_addr_o, card_addr_oe;
    logic wide = 1'b0;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    cwd_card_window_decoder dut (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_req(host_req),
        .host_io(host_io), .host_write(host_write), .host_addr(host_addr),
        .card_iois16_n(card_iois16_n), .host_claim(host_claim),
        .host_wp_drop(host_wp_drop), .card_req(card_req),
        .card_io(card_io), .card_write(card_write),
        .card_reg_n(card_reg_n), .card_tset(card_tset),
        .card_width16(card_width16), .card_addr_o(card_addr_o),
        .card_addr_oe(card_addr_oe), .zv_active(zv_active));

    cwd_card_model card (.clk(clk), .wide(wide),
        .card_iois16_n(card_iois16_n));

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Card fields: io, write, reg_n, tset, width16
    task automatic fld(input logic [4:0] exp);
        chk({27'h0, card_io, card_write, card_reg_n, card_tset,
            card_width16}, {27'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk({24'h0, reg_rdata}, {24'h0, exp});
    endtask

    // Expected pulses: claim, card_req, wp_drop; all low one cycle later
    task automatic acc(input logic io, input logic w, input logic [31:0] a,
                       input logic [2:0] exp);
        @(posedge clk);
        host_req <= 1'b1;
        host_io <= io;
        host_write <= w;
        host_addr <= a;
        @(posedge clk);
        host_req <= 1'b0;
        #1;
        chk({29'h0, host_claim, card_req, host_wp_drop}, {29'h0, exp});
        @(posedge clk);
        #1;
        chk({29'h0, host_claim, card_req, host_wp_drop}, 32'h0);
    endtask

    task automatic mwin(input int n, input logic [11:0] s,
        input logic [11:0] e, input logic [13:0] o, input logic [7:0] up,
        input logic [7:0] c);
        logic [7:0] b;
        b = `CWD_MEM_BASE + 8'(8 * n);
        wr(b, s[7:0]);
        wr(b + 8'h01, {4'h0, s[11:8]});
        wr(b + 8'h02, e[7:0]);
        wr(b + 8'h03, {4'h0, e[11:8]});
        wr(b + 8'h04, o[7:0]);
        wr(b + 8'h05, {2'h0, o[13:8]});
        wr(b + 8'h06, up);
        wr(b + 8'h07, c);
    endtask

    task automatic iowin(input int n, input logic [15:0] s,
        input logic [15:0] e, input logic [15:0] o, input logic [7:0] c);
        logic [7:0] b;
        b = `CWD_IO_BASE + 8'(8 * n);
        wr(b, s[7:0]);
        wr(b + 8'h01, s[15:8]);
        wr(b + 8'h02, e[7:0]);
        wr(b + 8'h03, e[15:8]);
        wr(b + 8'h04, o[7:0]);
        wr(b + 8'h05, o[15:8]);
        wr(b + 8'h06, c);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({5'h0, zv_active, card_addr_oe}, {5'h0, 1'b0, 26'h3ffffff});
        fld(5'b00100);
        rd(`CWD_MCTL_A, 8'h00);
        rd(`CWD_MCTL_C, 8'h00);
        acc(1'b0, 1'b0, 32'h0, 3'b000);
    endtask

    task automatic t_regs;
        wr(`CWD_MCTL_C, 8'h5a);
        rd(`CWD_MCTL_C, 8'h5a);
        wr(8'hfe, 8'h77);
        rd(8'hfe, 8'h00);
        wr(`CWD_MCTL_C, 8'h00);
    endtask

    task automatic t_mem_range;
        mwin(0, 12'h010, 12'h01f, 14'h0020, 8'h12, 8'h03);
        acc(1'b0, 1'b0, 32'h12010000, 3'b110);
        chk({6'h0, card_addr_o}, 32'h00030000);
        rd(`CWD_STAT_A, 8'h01);
        fld(5'b00111);
        acc(1'b0, 1'b0, 32'h1201ffff, 3'b110);
        chk({6'h0, card_addr_o}, 32'h0003ffff);
        acc(1'b0, 1'b0, 32'h1200ffff, 3'b000);
        acc(1'b0, 1'b0, 32'h12020000, 3'b000);
        acc(1'b0, 1'b0, 32'h13010000, 3'b000);
        acc(1'b1, 1'b0, 32'h12010000, 3'b000);
        wr(`CWD_MEM_BASE + 8'h07, 8'h02);
        acc(1'b0, 1'b0, 32'h12010000, 3'b000);
    endtask

    task automatic t_mem_attr;
        mwin(4, 12'h100, 12'h100, 14'h0000, 8'h00, 8'h0d);
        acc(1'b0, 1'b0, 32'h00100004, 3'b110);
        chk({6'h0, card_addr_o}, 32'h00100004);
        fld(5'b00001);
        acc(1'b0, 1'b1, 32'h00100004, 3'b101);
        fld(5'b00001);
        mwin(1, 12'hffe, 12'hfff, 14'h3fff, 8'h00, 8'h01);
        acc(1'b0, 1'b1, 32'h00ffe123, 3'b110);
        chk({6'h0, card_addr_o}, 32'h00ffd123);
        fld(5'b01101);
    endtask

    task automatic t_io;
        iowin(0, 16'h03f8, 16'h03ff, 16'h0100, 8'h11);
        wide <= 1'b1;
        repeat (4) @(posedge clk);
        acc(1'b1, 1'b0, 32'h000003f8, 3'b110);
        chk({6'h0, card_addr_o}, 32'h000004f8);
        fld(5'b10101);
        rd(`CWD_STAT_B, 8'h41);
        wide <= 1'b0;
        repeat (4) @(posedge clk);
        acc(1'b1, 1'b1, 32'h000003ff, 3'b110);
        chk({6'h0, card_addr_o}, 32'h000004ff);
        fld(5'b11100);
        acc(1'b1, 1'b0, 32'h00000400, 3'b000);
        acc(1'b1, 1'b0, 32'h000003f7, 3'b000);
        wide <= 1'b1;
        wr(`CWD_IO_BASE + 8'h06, 8'h15);
        repeat (4) @(posedge clk);
        acc(1'b1, 1'b0, 32'h000003f8, 3'b110);
        fld(5'b10100);
        wide <= 1'b0;
        wr(`CWD_IO_BASE + 8'h06, 8'h0f);
        repeat (4) @(posedge clk);
        acc(1'b1, 1'b0, 32'h000003f8, 3'b110);
        fld(5'b10111);
        iowin(1, 16'h0500, 16'h05ff, 16'h0000, 8'h02);
        acc(1'b1, 1'b0, 32'h00000500, 3'b000);
        wr(`CWD_IO_BASE + 8'h0e, 8'h03);
        acc(1'b1, 1'b0, 32'h000005ff, 3'b110);
        chk({6'h0, card_addr_o}, 32'h000005ff);
        fld(5'b10110);
        acc(1'b1, 1'b0, 32'h000105ff, 3'b000);
    endtask

    task automatic zv(input logic on);
        @(posedge clk);
        #1;
        chk({5'h0, zv_active, card_addr_oe},
            {5'h0, on, on ? 26'h000000f : 26'h3ffffff});
    endtask

    task automatic t_zv;
        wr(`CWD_MCTL_A, 8'h01);
        zv(1'b0);
        wr(`CWD_MCTL_C, 8'h80);
        zv(1'b1);
        wr(`CWD_MCTL_A, 8'h00);
        zv(1'b0);
        wr(`CWD_MCTL_A, 8'h01);
        zv(1'b1);
        wr(`CWD_MCTL_C, 8'h00);
        zv(1'b0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_regs();
        t_mem_range();
        t_mem_attr();
        t_io();
        t_zv();
        end_sim();
    end
endmodule
